// File: include/plc_cfg.svh
/*
 * Offsets, field positions, reset values and masks of the per-port lookup control registers.
 * Assumes a 16-bit register address whose upper nibble is the port number.
 */
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

`define PLC_NUM_PORTS      7
`define PLC_FIRST_PORT     3'h1
`define PLC_LAST_PORT      3'h7
`define PLC_NUM_TREES      8

`define PLC_OFS_CTRL       12'hB00
`define PLC_OFS_PTR        12'hB01
`define PLC_OFS_STATE      12'hB04

`define PLC_CTRL_NULL_VID  7
`define PLC_CTRL_ING_FILT  6
`define PLC_CTRL_NON_PVID  5
`define PLC_CTRL_MAC_AUTH  4
`define PLC_CTRL_SA_FILT   3
`define PLC_CTRL_RST       8'h00
`define PLC_CTRL_WMASK     8'hFA

`define PLC_PTR_RST        8'h00
`define PLC_PTR_LSB        0
`define PLC_PTR_MSB        2

`define PLC_ST_TX_EN       2
`define PLC_ST_RX_EN       1
`define PLC_ST_LRN_DIS     0
`define PLC_ST_RST         3'h6
`define PLC_ST_WIDTH       3

`define PLC_RD_UNMAPPED    8'h00

`endif

// File: include/plc_pkg.sv
/*
 * Types shared by the port lookup control register bank.
 * Assumes plc_cfg.svh is on the include path.
 */
`include "plc_cfg.svh"

package plc_pkg;
  typedef logic [2:0]                plc_port_t;
  typedef logic [2:0]                plc_tree_t;
  typedef logic [11:0]               plc_vid_t;
  typedef logic [47:0]               plc_mac_t;
  typedef logic [15:0]               plc_addr_t;
  typedef logic [7:0]                plc_byte_t;
  typedef logic [`PLC_ST_WIDTH-1:0]  plc_tstate_t;
endpackage

// File: rtl/plc_port_regs.sv
/*
 * One port's copy of the lookup control, tree pointer and eight tree-instance states.
 * Assumes the parent decodes the address and gives one-cycle write strobes.
 */
`include "plc_cfg.svh"

module plc_port_regs (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     wr_ctrl_in,
  input  wire logic                     wr_ptr_in,
  input  wire logic                     wr_state_in,
  input  wire plc_pkg::plc_byte_t       wdata_in,
  output plc_pkg::plc_byte_t            ctrl_out,
  output plc_pkg::plc_byte_t            ptr_out,
  output logic [3*`PLC_NUM_TREES-1:0]   states_out
);
  import plc_pkg::*;

  plc_byte_t   ctrl_ff;
  plc_byte_t   ptr_ff;
  plc_tstate_t state_ff [`PLC_NUM_TREES];
  plc_tree_t   sel_w;

  assign sel_w    = ptr_ff[`PLC_PTR_MSB:`PLC_PTR_LSB];
  assign ctrl_out = ctrl_ff;
  assign ptr_out  = ptr_ff;

  // Reserved read-only bits never store, so they read back as zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= `PLC_CTRL_RST;
      ptr_ff  <= `PLC_PTR_RST;
    end else begin
      if (wr_ctrl_in) ctrl_ff <= wdata_in & `PLC_CTRL_WMASK;
      if (wr_ptr_in)  ptr_ff  <= wdata_in;
    end
  end

  genvar t;
  generate
    for (t = 0; t < `PLC_NUM_TREES; t++) begin : g_tree
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          state_ff[t] <= `PLC_ST_RST;
        end else if (wr_state_in && sel_w == 3'(t)) begin
          state_ff[t] <= wdata_in[`PLC_ST_WIDTH-1:0];
        end
      end
      assign states_out[3*t +: 3] = state_ff[t];
    end
  endgenerate
endmodule // plc_port_regs

// File: rtl/plc_top.sv
/*
 * Per-port address lookup control registers for ports 1 to 7 and the frame
 * decisions they steer: lookup VID, ingress drops, learning and transmit permission.
 * Assumes register and lookup requests come from logic on clk_in, one per cycle.
 */
// How it works
// - Tagged VID zero uses zero or PVID
// - Ingress filtering drops non-member port frames
// - Optionally drop frames whose VID differs PVID
// - MAC 802.1X bit enables engine authentication
// - Drop frames sourced from switch's own MAC
// - Self filtering needs port and global enables
// - Three-bit pointer selects one of eight instances
// - State access reaches only pointed instance
// - Transmit enable, reset one, gates transmission
// - Receive enable, reset one, gates reception
// - Learning disable, reset zero, stops learning
`include "plc_cfg.svh"

module plc_top (
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Register access port
  input  wire plc_pkg::plc_addr_t   reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire plc_pkg::plc_byte_t   reg_wdata_in,
  output plc_pkg::plc_byte_t        reg_rdata_out,
  output logic                      reg_rvalid_out,
  // Ingress lookup request
  input  wire logic                 lk_valid_in,
  input  wire plc_pkg::plc_port_t   lk_port_in,
  input  wire logic                 lk_tagged_in,
  input  wire plc_pkg::plc_vid_t    lk_vid_in,
  input  wire plc_pkg::plc_vid_t    lk_pvid_in,
  input  wire logic [6:0]           lk_member_in,
  input  wire plc_pkg::plc_tree_t   lk_tree_in,
  input  wire plc_pkg::plc_mac_t    lk_sa_in,
  input  wire plc_pkg::plc_mac_t    sw_mac_in,
  input  wire logic                 sa_filt_global_in,
  // Ingress lookup answer
  output logic                      lk_done_out,
  output plc_pkg::plc_vid_t         lk_vid_out,
  output logic                      lk_drop_out,
  output logic                      lk_learn_out,
  output logic                      lk_auth_out,
  // Egress permission query
  input  wire plc_pkg::plc_port_t   tx_port_in,
  input  wire plc_pkg::plc_tree_t   tx_tree_in,
  output logic                      tx_allow_out
);
  import plc_pkg::*;

  plc_byte_t                    ctrl_w   [1:`PLC_NUM_PORTS];
  plc_byte_t                    ptr_w    [1:`PLC_NUM_PORTS];
  logic [3*`PLC_NUM_TREES-1:0]  states_w [1:`PLC_NUM_PORTS];

  // Address decode: upper nibble picks the port, lower twelve bits the register
  plc_port_t   acc_port_w;
  logic [11:0] acc_ofs_w;
  logic        port_ok_w;
  logic        hit_ctrl_w;
  logic        hit_ptr_w;
  logic        hit_state_w;
  logic        wr_ctrl_w;
  logic        wr_ptr_w;
  logic        wr_state_w;

  assign acc_port_w  = reg_addr_in[14:12];
  assign acc_ofs_w   = reg_addr_in[11:0];
  assign port_ok_w   = (reg_addr_in[15] == 1'b0) && (acc_port_w != 3'h0);
  assign hit_ctrl_w  = port_ok_w && acc_ofs_w == `PLC_OFS_CTRL;
  assign hit_ptr_w   = port_ok_w && acc_ofs_w == `PLC_OFS_PTR;
  assign hit_state_w = port_ok_w && acc_ofs_w == `PLC_OFS_STATE;
  // Writes to unmapped offsets or ports fall through with no effect
  assign wr_ctrl_w   = reg_wr_in && hit_ctrl_w;
  assign wr_ptr_w    = reg_wr_in && hit_ptr_w;
  assign wr_state_w  = reg_wr_in && hit_state_w;

  genvar p;
  generate
    for (p = 1; p <= `PLC_NUM_PORTS; p++) begin : g_port
      logic sel_w;
      assign sel_w = acc_port_w == 3'(p);
      plc_port_regs u_regs (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .wr_ctrl_in  (sel_w && wr_ctrl_w),
        .wr_ptr_in   (sel_w && wr_ptr_w),
        .wr_state_in (sel_w && wr_state_w),
        .wdata_in    (reg_wdata_in),
        .ctrl_out    (ctrl_w[p]),
        .ptr_out     (ptr_w[p]),
        .states_out  (states_w[p])
      );
    end
  endgenerate

  // Read mux; the state register shows only the pointed instance
  plc_byte_t   rd_ctrl_w;
  plc_byte_t   rd_ptr_w;
  plc_tree_t   rd_tree_w;
  plc_tstate_t rd_state_w;
  logic [3*`PLC_NUM_TREES-1:0] rd_states_w;
  plc_byte_t   nxt_rdata;
  plc_byte_t   rdata_ff;
  logic        rvalid_ff;

  assign rd_ctrl_w  = port_ok_w ? ctrl_w[acc_port_w] : `PLC_RD_UNMAPPED;
  assign rd_ptr_w   = port_ok_w ? ptr_w[acc_port_w] : `PLC_RD_UNMAPPED;
  assign rd_tree_w  = rd_ptr_w[`PLC_PTR_MSB:`PLC_PTR_LSB];
  assign rd_states_w = port_ok_w ? states_w[acc_port_w] : '0;
  assign rd_state_w  = rd_states_w[3*rd_tree_w +: 3];
  assign nxt_rdata  = hit_ctrl_w  ? rd_ctrl_w :
                      hit_ptr_w   ? rd_ptr_w :
                      hit_state_w ? {5'h00, rd_state_w} :
                                    `PLC_RD_UNMAPPED;

  // Read data stay registered until the next read, so a slow reader still sees them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff  <= `PLC_RD_UNMAPPED;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd_in;
      if (reg_rd_in) rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_out  = rdata_ff;
  assign reg_rvalid_out = rvalid_ff;

  // Ingress lookup decision
  logic        lk_port_ok_w;
  plc_byte_t   lk_ctrl_w;
  plc_tstate_t lk_state_w;
  logic [3*`PLC_NUM_TREES-1:0] lk_states_w;
  plc_port_t   lk_mbit_w;
  logic        null_tag_w;
  plc_vid_t    eff_vid_w;
  logic        not_member_w;
  logic        bad_pvid_w;
  logic        self_sa_w;
  logic        rx_block_w;
  logic        nxt_drop;
  logic        nxt_learn;

  assign lk_port_ok_w = lk_port_in != 3'h0;
  assign lk_ctrl_w    = lk_port_ok_w ? ctrl_w[lk_port_in] : `PLC_CTRL_RST;
  // Port zero reads an all-zero state, so its frames also count as blocked
  assign lk_states_w  = lk_port_ok_w ? states_w[lk_port_in] : '0;
  assign lk_state_w   = lk_states_w[3*lk_tree_in +: 3];
  // Port zero would index past the membership vector, so it is steered to bit 0
  assign lk_mbit_w    = lk_port_ok_w ? lk_port_in - 3'h1 : 3'h0;
  assign null_tag_w   = lk_tagged_in && lk_vid_in == 12'h000;
  // Untagged frames classify to the port default VID as well
  assign eff_vid_w    = (!lk_tagged_in || (null_tag_w && !lk_ctrl_w[`PLC_CTRL_NULL_VID]))
                        ? lk_pvid_in : lk_vid_in;
  assign not_member_w = lk_ctrl_w[`PLC_CTRL_ING_FILT] &&
                        !lk_member_in[lk_mbit_w];
  assign bad_pvid_w   = lk_ctrl_w[`PLC_CTRL_NON_PVID] && eff_vid_w != lk_pvid_in;
  assign self_sa_w    = lk_ctrl_w[`PLC_CTRL_SA_FILT] && sa_filt_global_in &&
                        lk_sa_in == sw_mac_in;
  assign rx_block_w   = !lk_state_w[`PLC_ST_RX_EN];
  // A port number of zero does not exist, so its frames are dropped
  assign nxt_drop     = !lk_port_ok_w || not_member_w || bad_pvid_w ||
                        self_sa_w || rx_block_w;
  // Dropped frames still teach addresses unless reception is blocked, learning is disabled or the port is zero
  assign nxt_learn    = lk_port_ok_w && !rx_block_w &&
                        !lk_state_w[`PLC_ST_LRN_DIS];

  // Answer fields hold until the next request; done marks a fresh one
  logic      done_ff;
  plc_vid_t  vid_ff;
  logic      drop_ff;
  logic      learn_ff;
  logic      auth_ff;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_ff  <= 1'b0;
      vid_ff   <= 12'h000;
      drop_ff  <= 1'b0;
      learn_ff <= 1'b0;
      auth_ff  <= 1'b0;
    end else begin
      done_ff <= lk_valid_in;
      if (lk_valid_in) begin
        vid_ff   <= eff_vid_w;
        drop_ff  <= nxt_drop;
        learn_ff <= nxt_learn;
        auth_ff  <= lk_ctrl_w[`PLC_CTRL_MAC_AUTH];
      end
    end
  end

  assign lk_done_out  = done_ff;
  assign lk_vid_out   = vid_ff;
  assign lk_drop_out  = drop_ff;
  assign lk_learn_out = learn_ff;
  assign lk_auth_out  = auth_ff;

  // Egress permission, one cycle after the query
  logic                        tx_port_ok_w;
  plc_port_t                   tx_sel_port_w;
  logic [3*`PLC_NUM_TREES-1:0] tx_states_w;
  plc_tstate_t                 tx_state_w;
  logic                        nxt_tx_allow;
  logic                        tx_allow_ff;

  assign tx_port_ok_w  = tx_port_in != 3'h0;
  // Port zero is steered to a real copy to keep the index in range; its answer stays 0
  assign tx_sel_port_w = tx_port_ok_w ? tx_port_in : `PLC_FIRST_PORT;
  assign tx_states_w   = states_w[tx_sel_port_w];
  assign tx_state_w    = tx_states_w[3*tx_tree_in +: 3];
  assign nxt_tx_allow  = tx_port_ok_w && tx_state_w[`PLC_ST_TX_EN];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) tx_allow_ff <= 1'b0;
    else        tx_allow_ff <= nxt_tx_allow;
  end

  assign tx_allow_out = tx_allow_ff;
endmodule // plc_top

// File: bench/plc_top_monitor.sv
/* Checker on the plc_top ports: register and lookup handshakes, lookup VID choice.
   Assumes it is bound into plc_top, with one clock and an asynchronous high reset. */
module plc_top_monitor (
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire plc_pkg::plc_addr_t reg_addr_in,
  input wire logic               reg_rd_in,
  input wire plc_pkg::plc_byte_t reg_rdata_out,
  input wire logic               reg_rvalid_out,
  input wire logic               lk_valid_in,
  input wire plc_pkg::plc_port_t lk_port_in,
  input wire logic               lk_tagged_in,
  input wire plc_pkg::plc_vid_t  lk_vid_in,
  input wire plc_pkg::plc_vid_t  lk_pvid_in,
  input wire logic               lk_done_out,
  input wire plc_pkg::plc_vid_t  lk_vid_out,
  input wire logic               lk_drop_out,
  input wire logic               lk_learn_out,
  input wire plc_pkg::plc_port_t tx_port_in,
  input wire logic               tx_allow_out
);
  import plc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_rd_answer;
    reg_rd_in ##1 reg_rvalid_out;
  endsequence
  // Port nibble 0 or 8..F selects no copy
  sequence s_rd_unmapped;
    reg_rd_in && (reg_addr_in[15:12] == 4'h0 || reg_addr_in[15]);
  endsequence
  AST_RD_ANSWER: assert property (reg_rd_in |-> s_rd_answer)
    else $error("read not answered one cycle later");
  AST_RVALID_CAUSE: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read valid without a read");
  AST_RD_UNMAPPED: assert property (s_rd_unmapped |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_LK_DONE: assert property (lk_valid_in |=> lk_done_out ##1 !lk_done_out || $past(lk_valid_in))
    else $error("lookup done timing wrong");
  AST_VID_UNTAG: assert property (lk_valid_in && !lk_tagged_in |=> lk_vid_out == $past(lk_pvid_in))
    else $error("untagged lookup VID not default");
  AST_VID_TAG: assert property (lk_valid_in && lk_tagged_in && lk_vid_in != 12'h000
    |=> lk_vid_out == $past(lk_vid_in))
    else $error("tagged lookup VID not frame VID");
  AST_PORT0: assert property (lk_valid_in && lk_port_in == 3'h0 |=> lk_drop_out && !lk_learn_out)
    else $error("port zero frame not dropped");
  AST_LK_HOLD: assert property (!lk_valid_in |=> $stable(lk_vid_out) && $stable(lk_drop_out))
    else $error("lookup answer changed without request");
  AST_TX_PORT0: assert property (tx_port_in == 3'h0 |=> !tx_allow_out)
    else $error("transmit allowed on port zero");
endmodule // plc_top_monitor

bind plc_top plc_top_monitor u_mon (.clk_in, .rst_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out,
  .reg_rvalid_out, .lk_valid_in, .lk_port_in, .lk_tagged_in, .lk_vid_in, .lk_pvid_in,
  .lk_done_out, .lk_vid_out, .lk_drop_out, .lk_learn_out, .tx_port_in, .tx_allow_out);

// File: bench/tb_plc_top.sv
/* Self-checking bench for plc_top: register access, tree states, lookup decisions.
   Assumes plc_pkg is compiled first and the monitor binds itself into the design. */
module tb_plc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import plc_pkg::*;
  localparam plc_vid_t PVID    = 12'h00A;
  localparam plc_mac_t OWN_MAC = 48'h0200_0000_0A01;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  plc_addr_t  addr = 16'h0000;
  logic       wr = 1'b0, rd = 1'b0, lv = 1'b0, tg = 1'b0, sg = 1'b0;
  plc_byte_t  wd = 8'h00, rdata;
  logic       rvalid, done, drop, learn, auth, allow;
  plc_port_t  lp = 3'h1, tp = 3'h1;
  plc_tree_t  lt = 3'h0, tt = 3'h0;
  plc_vid_t   vid = 12'h000, vid_o;
  logic [6:0] mem = 7'h00;
  plc_mac_t   sa = 48'h0000_0000_0001;
  int         fail_count = 0, checks_done = 0;
  always #2 clk_in = ~clk_in;
  plc_top dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .lk_valid_in(lv), .lk_port_in(lp), .lk_tagged_in(tg), .lk_vid_in(vid), .lk_pvid_in(PVID),
    .lk_member_in(mem), .lk_tree_in(lt), .lk_sa_in(sa), .sw_mac_in(OWN_MAC),
    .sa_filt_global_in(sg), .lk_done_out(done), .lk_vid_out(vid_o), .lk_drop_out(drop),
    .lk_learn_out(learn), .lk_auth_out(auth), .tx_port_in(tp), .tx_tree_in(tt),
    .tx_allow_out(allow));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr_reg(input plc_addr_t a, input plc_byte_t d);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input plc_addr_t a, input plc_byte_t e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    chk("read", {8'h01, e}, {7'h00, rvalid, rdata});
  endtask
  task automatic tx(input plc_port_t p, input plc_tree_t t, input logic e);
    @(posedge clk_in);
    tp <= p;
    tt <= t;
    @(posedge clk_in);
    #1;
    chk("tx_allow", {15'h0000, e}, {15'h0000, allow});
  endtask
  // Expected word is {done, vid, drop, learn, auth}; s picks the switch's own source MAC
  task automatic look(input plc_port_t p, input logic t, input plc_tree_t tr, input plc_vid_t v,
                      input logic [6:0] m, input logic s, input logic g, input logic [15:0] e);
    @(posedge clk_in);
    lp <= p;
    tg <= t;
    lt <= tr;
    vid <= v;
    mem <= m;
    sa <= s ? OWN_MAC : 48'h0000_0000_0001;
    sg <= g;
    lv <= 1'b1;
    @(posedge clk_in);
    lv <= 1'b0;
    #1;
    chk("lookup", e, {done, vid_o, drop, learn, auth});
  endtask
  initial begin
    #20000;
    fail_count++;
    conclude();
  end
  initial begin
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_reg(16'h1B00, 8'h00);
      rd_reg(16'h1B01, 8'h00);
      rd_reg(16'h1B04, 8'h06);
      tx(3'h3, 3'h5, 1'b1);
      tx(3'h0, 3'h5, 1'b0);
      wr_reg(16'h1B00, 8'hFF);
      rd_reg(16'h1B00, 8'hFA);
    end
    for (int t = 0; t < 8; t++) begin
      wr_reg(16'h1B01, 8'(t));
      wr_reg(16'h1B04, 8'(t));
    end
    // Upper pointer bits are storage only and must not change the selection
    for (int t = 0; t < 8; t++) begin
      wr_reg(16'h1B01, {5'h1F, 3'(t)});
      rd_reg(16'h1B04, 8'(t));
      tx(3'h1, 3'(t), t[2]);
    end
    rd_reg(16'h1B01, 8'hFF);
    wr_reg(16'h1B04, 8'hFF);
    rd_reg(16'h1B04, 8'h07);
    rd_reg(16'h2B04, 8'h06);
    rd_reg(16'h0B00, 8'h00);
    rd_reg(16'h8B00, 8'h00);
    wr_reg(16'h9B00, 8'h00);
    rd_reg(16'h1B00, 8'hFA);
    rd_reg(16'h1B02, 8'h00);
    look(3'h1, 1'b1, 3'h6, 12'h000, 7'h01, 1'b0, 1'b0, {1'b1, 12'h000, 3'h7});
    look(3'h2, 1'b1, 3'h0, 12'h000, 7'h00, 1'b1, 1'b1, {1'b1, PVID, 3'h2});
    look(3'h1, 1'b1, 3'h6, PVID, 7'h01, 1'b0, 1'b1, {1'b1, PVID, 3'h3});
    look(3'h1, 1'b1, 3'h6, PVID, 7'h7E, 1'b0, 1'b1, {1'b1, PVID, 3'h7});
    look(3'h1, 1'b1, 3'h6, PVID, 7'h01, 1'b1, 1'b1, {1'b1, PVID, 3'h7});
    look(3'h1, 1'b1, 3'h6, PVID, 7'h01, 1'b1, 1'b0, {1'b1, PVID, 3'h3});
    look(3'h1, 1'b1, 3'h6, 12'h123, 7'h01, 1'b0, 1'b0, {1'b1, 12'h123, 3'h7});
    look(3'h1, 1'b0, 3'h6, 12'h123, 7'h01, 1'b0, 1'b0, {1'b1, PVID, 3'h3});
    look(3'h1, 1'b1, 3'h1, PVID, 7'h01, 1'b0, 1'b0, {1'b1, PVID, 3'h5});
    look(3'h1, 1'b1, 3'h3, PVID, 7'h01, 1'b0, 1'b0, {1'b1, PVID, 3'h1});
    look(3'h2, 1'b1, 3'h0, 12'h123, 7'h00, 1'b0, 1'b0, {1'b1, 12'h123, 3'h2});
    look(3'h0, 1'b0, 3'h0, PVID, 7'h7F, 1'b0, 1'b0, {1'b1, PVID, 3'h4});
    conclude();
  end
endmodule // tb_plc_top
